// file: include/eac_map.svh
`ifndef EAC_MAP_SVH
`define EAC_MAP_SVH

// Command codes seen by this block
`define EAC_CMD_RESTORE_DEF 16'h0012
`define EAC_CMD_STORE_USER 16'h0015
`define EAC_CMD_RESTORE_USER 16'h0016
`define EAC_CMD_DATA_HI 12'h00B
`define EAC_CMD_CHKSUM 16'h00D1
`define EAC_CMD_RD_CNT 16'h00D2
`define EAC_CMD_OFFSET 16'h00D3
`define EAC_CMD_ERASE 16'h00D4
`define EAC_CMD_PASSWORD 16'h00D5
`define EAC_CMD_FLAGS 16'hFE81

// Status flag bit positions
`define EAC_FLAG_UNLOCK 6
`define EAC_FLAG_CRC 5
`define EAC_FLAG_BUSY 0

// Reset and fill values
`define EAC_PW_DEFAULT 8'hFF
`define EAC_INVALID 8'h00
`define EAC_ERASED 8'hFF
`define EAC_RD_CNT_RST 8'h01
`define EAC_OFFSET_RST 16'h0000

// Page layout
`define EAC_PAGE_FACTORY 4'h0
`define EAC_PAGE_USER 4'h1
`define EAC_PAGE_MIN 4'h2
`define EAC_PAGE_LAST 9'h1FF
`define EAC_MAX_XFER 9'h100

// Timing: busy time after erase or store
`define EAC_BUSY_MS 35
`define EAC_CLK_KHZ 125000

`endif

// file: include/eac_pkg.sv
package eac_pkg;

  // One transaction opened by the bus slave
  typedef struct packed {
    logic [15:0] code;
    logic write;
  } eac_txn_t;

  // Controller sequencer states
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_FETCH = 6'h02,
    ST_LOAD  = 6'h04,
    ST_ERASE = 6'h08,
    ST_STORE = 6'h10,
    ST_WAIT  = 6'h20
  } eac_state_t;

endpackage : eac_pkg

// file: core/eac_ctrl.sv
`include "eac_map.svh"

module eac_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] buf_mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Honest full and empty from the occupancy count
  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = buf_mem[rd_ptr_reg];

  // Storage has no reset; only pointers and the count need a known value
  always_ff @(posedge sys_clk) begin
    if (push) begin
      buf_mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : eac_fifo

module eac_ctrl
  import eac_pkg::*;
#(
  parameter int NUM_SET = 32,
  parameter int FIFO_DEPTH = 8,
  parameter int unsigned BUSY_CYCLES = `EAC_BUSY_MS * `EAC_CLK_KHZ
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Transaction opened by the bus slave
  input wire logic tx_start,
  input wire eac_txn_t tx_req,
  // Written bytes and their answer
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic wr_ack,
  output logic wr_nack,
  // Read byte stream
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  // Internal settings registers
  input wire logic set_we,
  input wire logic [$clog2(NUM_SET)-1:0] set_addr,
  input wire logic [7:0] set_wdata,
  input wire logic [$clog2(NUM_SET)-1:0] set_rd_addr,
  output logic [7:0] set_rd_data,
  // Status
  output logic busy
);
  localparam int SW = $clog2(NUM_SET);
  localparam int BW = $clog2(BUSY_CYCLES + 1);
  localparam logic [8:0] SET_END = 9'(NUM_SET);

  // Main block: 16 pages of 512 bytes
  // Starts erased; contents are kept across resets
  logic [7:0] nv_mem [8192] = '{default: `EAC_ERASED};
  logic [7:0] set_mem [NUM_SET];

  eac_state_t state_reg;
  logic [15:0] tx_code_reg;
  logic tx_wr_reg;
  logic [8:0] byte_idx_reg;
  logic [8:0] work_idx_reg;
  logic [8:0] fetch_len_reg;
  logic fetch_mem_reg;
  logic [3:0] op_page_reg;
  logic store_pend_reg;
  logic [BW-1:0] wait_cnt_reg;
  logic [7:0] acc_reg;
  logic [7:0] chk_reg;
  logic crc_fault_reg;
  logic [7:0] rd_cnt_reg;
  logic [15:0] offset_reg;
  logic [7:0] pw_reg;
  logic pw_hit_reg;
  logic unlocked_reg;
  logic ack_reg;
  logic nack_reg;
  logic [7:0] set_rd_reg;

  // Count of ones in one byte
  function automatic logic [7:0] ones(input logic [7:0] b);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < 8; i++) begin
      n = n + {7'h00, b[i]};
    end
    return n;
  endfunction : ones

  // Data command test, shared by both transaction decode points
  function automatic logic is_data(input logic [15:0] code);
    return code[15:4] == `EAC_CMD_DATA_HI;
  endfunction : is_data

  // Transaction decode
  wire idle = (state_reg == ST_IDLE);
  wire tx_data = is_data(tx_code_reg);
  wire [3:0] tx_page = tx_code_reg[3:0];
  wire page_reserved = (tx_page < `EAC_PAGE_MIN);
  wire req_data = is_data(tx_req.code);
  wire req_reg1 = (tx_req.code == `EAC_CMD_CHKSUM) ||
                  (tx_req.code == `EAC_CMD_RD_CNT) ||
                  (tx_req.code == `EAC_CMD_FLAGS);
  wire req_off = (tx_req.code == `EAC_CMD_OFFSET);
  wire start_rd = tx_start && idle && !tx_req.write &&
                  (req_data || req_reg1 || req_off);
  wire start_def = tx_start && idle && tx_req.write &&
                   (tx_req.code == `EAC_CMD_RESTORE_DEF);
  wire start_usr = tx_start && idle && tx_req.write &&
                   (tx_req.code == `EAC_CMD_RESTORE_USER);
  wire start_sto = tx_start && idle && tx_req.write && unlocked_reg &&
                   (tx_req.code == `EAC_CMD_STORE_USER);

  // Zero count means a full 256-byte block
  wire [8:0] rd_len = (rd_cnt_reg == 8'h00) ? `EAC_MAX_XFER
                                            : {1'b0, rd_cnt_reg};
  wire [8:0] start_len = req_data ? rd_len : (req_off ? 9'h002 : 9'h001);

  // Written byte decode; busy sequences refuse everything
  wire wr_now = wr_valid && idle && tx_wr_reg;
  wire in_range = (byte_idx_reg < `EAC_MAX_XFER);
  wire data_wr_ok = wr_now && tx_data && unlocked_reg &&
                    !page_reserved && in_range;
  wire first_byte = (byte_idx_reg == 9'h000);
  wire cnt_wr = wr_now && first_byte && (tx_code_reg == `EAC_CMD_RD_CNT);
  wire off_wr = wr_now && (byte_idx_reg < 9'h002) &&
                (tx_code_reg == `EAC_CMD_OFFSET);
  wire pw_wr = wr_now && first_byte && (tx_code_reg == `EAC_CMD_PASSWORD);
  wire erase_wr = wr_now && first_byte && unlocked_reg &&
                  (tx_code_reg == `EAC_CMD_ERASE) && (wr_data[7:4] == 4'h0) &&
                  (wr_data[3:0] >= `EAC_PAGE_MIN);
  wire wr_accept = data_wr_ok || cnt_wr || off_wr || pw_wr || erase_wr;
  wire pw_match = (wr_data == pw_reg);

  // Shared memory port; program only clears bits, erase sets them
  wire [8:0] page_pos = 9'(offset_reg[8:0] +
                           (state_reg == ST_FETCH ? work_idx_reg
                                                  : byte_idx_reg));
  wire [12:0] mem_addr = (state_reg == ST_FETCH || idle) ?
                         {tx_page, page_pos} : {op_page_reg, work_idx_reg};
  wire [7:0] mem_rdata = nv_mem[mem_addr];
  wire work_last_set = (work_idx_reg == SET_END);
  wire [7:0] set_cur = set_mem[work_idx_reg[SW-1:0]];
  wire [7:0] store_byte = work_last_set ? acc_reg : set_cur;
  wire mem_erase = (state_reg == ST_ERASE);
  wire mem_we = mem_erase || (state_reg == ST_STORE) || data_wr_ok;
  wire [7:0] mem_wdata = data_wr_ok ? wr_data : store_byte;

  // Read stream source
  wire [7:0] flags_byte = {1'b0, unlocked_reg, crc_fault_reg, 4'h0,
                           !idle};
  wire [7:0] reg_byte =
    (tx_code_reg == `EAC_CMD_CHKSUM) ? chk_reg :
    (tx_code_reg == `EAC_CMD_RD_CNT) ? rd_cnt_reg :
    (tx_code_reg == `EAC_CMD_OFFSET) ?
      (work_idx_reg[0] ? offset_reg[15:8] : offset_reg[7:0]) :
    (tx_code_reg == `EAC_CMD_FLAGS) ? flags_byte : 8'h00;
  wire hide = page_reserved && !unlocked_reg;
  wire [7:0] mem_byte = hide ? `EAC_INVALID : mem_rdata;
  wire [7:0] push_byte = fetch_mem_reg ? mem_byte : reg_byte;
  wire push_valid = (state_reg == ST_FETCH);
  wire push_ready;
  wire push_done = push_valid && push_ready &&
                   (work_idx_reg == 9'(fetch_len_reg - 9'h001));

  assign wr_ack = ack_reg;
  assign wr_nack = nack_reg;
  assign set_rd_data = set_rd_reg;
  assign busy = !idle;

  // Read bytes queue here so the slave may stall the fetch
  eac_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_rd_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_byte),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  // Single write port; no sequence targets page zero
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      nv_mem[mem_addr] <= mem_erase ? `EAC_ERASED : (mem_rdata & mem_wdata);
    end
  end

  // Settings: download wins over writes on the set_we port
  always_ff @(posedge sys_clk) begin
    if (state_reg == ST_LOAD && !work_last_set) begin
      set_mem[work_idx_reg[SW-1:0]] <= mem_rdata;
    end else if (set_we) begin
      set_mem[set_addr] <= set_wdata;
    end
    set_rd_reg <= set_mem[set_rd_addr];
  end

  // Transaction tracking and byte answers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_code_reg <= 16'h0000;
      tx_wr_reg <= 1'b0;
      byte_idx_reg <= 9'h000;
      ack_reg <= 1'b0;
      nack_reg <= 1'b0;
    end else begin
      ack_reg <= wr_valid && wr_accept;
      nack_reg <= wr_valid && !wr_accept;
      if (tx_start) begin
        tx_code_reg <= tx_req.code;
        tx_wr_reg <= tx_req.write;
        byte_idx_reg <= 9'h000;
      end else if (wr_accept) begin
        byte_idx_reg <= byte_idx_reg + 9'h001;
      end
    end
  end

  // Host-visible settings of the access path
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_cnt_reg <= `EAC_RD_CNT_RST;
      offset_reg <= `EAC_OFFSET_RST;
    end else begin
      if (cnt_wr) begin
        rd_cnt_reg <= wr_data;
      end
      if (off_wr && first_byte) begin
        offset_reg[7:0] <= wr_data;
      end else if (off_wr) begin
        offset_reg[15:8] <= wr_data;
      end
    end
  end

  // Lock logic: a hit arms either unlock or a password change
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pw_reg <= `EAC_PW_DEFAULT;
      pw_hit_reg <= 1'b0;
      unlocked_reg <= 1'b0;
    end else if (start_def) begin
      pw_reg <= `EAC_PW_DEFAULT;
      pw_hit_reg <= 1'b0;
    end else if (pw_wr) begin
      if (unlocked_reg && pw_hit_reg) begin
        pw_reg <= wr_data;
        pw_hit_reg <= 1'b0;
      end else if (pw_match && pw_hit_reg) begin
        unlocked_reg <= 1'b1;
        pw_hit_reg <= 1'b0;
      end else if (pw_match) begin
        pw_hit_reg <= 1'b1;
      end else begin
        unlocked_reg <= 1'b0;
        pw_hit_reg <= 1'b0;
      end
    end else if (tx_start && (tx_req.code != `EAC_CMD_PASSWORD)) begin
      // Pair spans two transactions; another command or a wrong password byte breaks it
      pw_hit_reg <= 1'b0;
    end
  end

  // Sequencer; reset starts the power-up download of the user page
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= ST_LOAD;
      op_page_reg <= `EAC_PAGE_USER;
      work_idx_reg <= 9'h000;
      fetch_len_reg <= 9'h001;
      fetch_mem_reg <= 1'b0;
      store_pend_reg <= 1'b0;
      wait_cnt_reg <= '0;
      acc_reg <= 8'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          work_idx_reg <= 9'h000;
          acc_reg <= 8'h00;
          wait_cnt_reg <= '0;
          if (start_rd) begin
            state_reg <= ST_FETCH;
            fetch_len_reg <= start_len;
            fetch_mem_reg <= req_data;
          end else if (start_def) begin
            state_reg <= ST_LOAD;
            op_page_reg <= `EAC_PAGE_FACTORY;
          end else if (start_usr) begin
            state_reg <= ST_LOAD;
            op_page_reg <= `EAC_PAGE_USER;
          end else if (start_sto) begin
            state_reg <= ST_ERASE;
            op_page_reg <= `EAC_PAGE_USER;
            store_pend_reg <= 1'b1;
          end else if (erase_wr) begin
            state_reg <= ST_ERASE;
            op_page_reg <= wr_data[3:0];
            store_pend_reg <= 1'b0;
          end
        end
        ST_FETCH: begin
          if (push_done) begin
            state_reg <= ST_IDLE;
          end else if (push_ready) begin
            work_idx_reg <= work_idx_reg + 9'h001;
          end
        end
        ST_LOAD: begin
          // Eight-bit accumulator wraps on its own
          if (work_last_set) begin
            state_reg <= ST_IDLE;
          end else begin
            acc_reg <= acc_reg + ones(mem_rdata);
            work_idx_reg <= work_idx_reg + 9'h001;
          end
        end
        ST_ERASE: begin
          work_idx_reg <= work_idx_reg + 9'h001;
          if (work_idx_reg == `EAC_PAGE_LAST) begin
            state_reg <= store_pend_reg ? ST_STORE : ST_WAIT;
          end
        end
        ST_STORE: begin
          if (work_last_set) begin
            state_reg <= ST_WAIT;
          end else begin
            acc_reg <= acc_reg + ones(set_cur);
            work_idx_reg <= work_idx_reg + 9'h001;
          end
        end
        ST_WAIT: begin
          // Holds busy for the full programming time
          wait_cnt_reg <= wait_cnt_reg + 1'b1;
          if (wait_cnt_reg == BW'(BUSY_CYCLES - 1)) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Checksum result latched at the end of each download
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      chk_reg <= 8'h00;
      crc_fault_reg <= 1'b0;
    end else if (state_reg == ST_LOAD && work_last_set) begin
      chk_reg <= acc_reg;
      crc_fault_reg <= (acc_reg != mem_rdata);
    end
  end
endmodule : eac_ctrl

// file: sim/eac_ctrl_asserts.sv
module eac_ctrl_asserts
  import eac_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Requests
  input wire logic tx_start,
  input wire eac_txn_t tx_req,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  input wire logic rd_ready,
  // Answers
  input wire logic wr_ack,
  input wire logic wr_nack,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] code_reg;

  // Latest command code; one sent while busy is still recorded
  always_ff @(posedge sys_clk) begin
    if (!rst_n) code_reg <= 16'h0000;
    else if (tx_start) code_reg <= tx_req.code;
  end

  // Data commands aimed at the factory or user page
  wire page_lo = code_reg[15:4] == 12'h00B && code_reg[3:1] == 3'h0;
  wire bad_page = wr_data < 8'h02 || wr_data > 8'h0F;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_wr_answer: assert property (
    wr_valid |=> $onehot({wr_ack, wr_nack}))
    else $error("written byte not answered exactly once");
  a_answer_cause: assert property (
    wr_ack || wr_nack |-> $past(wr_valid))
    else $error("answer without a written byte");
  a_busy_nack: assert property (
    wr_valid && busy |=> wr_nack)
    else $error("byte taken while busy");
  a_page_nack: assert property (
    wr_valid && page_lo |=> wr_nack)
    else $error("write to reserved page not refused");
  a_erase_range: assert property (
    wr_valid && code_reg == 16'h00D4 && bad_page |=> wr_nack)
    else $error("erase outside pages two to fifteen taken");
  a_sum_read: assert property (
    tx_start && !busy && !tx_req.write && tx_req.code == 16'h00D1
    |-> ##[1:3] rd_valid)
    else $error("checksum byte did not appear");
  a_rd_hold: assert property (
    rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("read byte changed while stalled");
  a_user_load: assert property (
    tx_start && !busy && tx_req.write && tx_req.code == 16'h0016
    |=> busy [*8])
    else $error("user reload not started");
  a_fact_load: assert property (
    tx_start && !busy && tx_req.write && tx_req.code == 16'h0012
    |=> busy [*8])
    else $error("factory reload not started");
  a_power_load: assert property (
    $rose(rst_n) |=> busy [*8])
    else $error("power-up download not started");

  // Main scenarios reached
  c_ack: cover property (wr_ack);
  c_stall: cover property (rd_valid && !rd_ready);
  c_done: cover property ($fell(busy));
endmodule : eac_ctrl_asserts

bind eac_ctrl eac_ctrl_asserts u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .tx_start(tx_start), .tx_req(tx_req), .wr_valid(wr_valid),
  .wr_data(wr_data), .rd_ready(rd_ready), .wr_ack(wr_ack),
  .wr_nack(wr_nack), .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy));

// file: sim/eac_host.sv
module eac_host
  import eac_pkg::*;
(
  // Clock and answers from the core
  input wire logic sys_clk,
  input wire logic busy,
  input wire logic wr_ack,
  input wire logic wr_nack,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  // Requests toward the core
  output logic tx_start,
  output eac_txn_t tx_req,
  output logic wr_valid,
  output logic [7:0] wr_data,
  output logic rd_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] q[$];
  bit slow;

  // Idle levels at time zero
  initial begin
    tx_start = 1'b0;
    tx_req = '0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    rd_ready = 1'b0;
    slow = 1'b0;
  end

  // Opens a command once erase, store or download has finished
  task automatic cmd(input logic [15:0] c, input logic w);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (busy !== 1'b0 && n < 5000) begin
      @(negedge sys_clk);
      n++;
    end
    tx_start = 1'b1;
    tx_req = '{code: c, write: w};
    @(negedge sys_clk);
    tx_start = 1'b0;
    q.delete();
  endtask : cmd

  // One byte after an idle edge, so back-to-back calls never glue strobes
  // Data is scrambled once released so stale values never help
  task automatic wb(input logic [7:0] d, output logic ok);
    @(negedge sys_clk);
    wr_valid = 1'b1;
    wr_data = d;
    @(negedge sys_clk);
    wr_valid = 1'b0;
    wr_data = ~d;
    ok = (wr_ack === 1'b1) ? 1'b1 : ((wr_nack === 1'b1) ? 1'b0 : 1'bx);
  endtask : wb

  // Drains n bytes; slow mode stalls every other cycle to fill the buffer
  task automatic rd(input int n);
    int t;
    t = 0;
    while (q.size() < n && t < 4000) begin
      rd_ready = slow ? t[0] : 1'b1;
      if (rd_ready && rd_valid === 1'b1) q.push_back(rd_data);
      @(negedge sys_clk);
      t++;
    end
    rd_ready = 1'b0;
  endtask : rd
endmodule : eac_host

// file: sim/eac_ctrl_tb.sv
module eac_ctrl_tb
  import eac_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rst_n, set_we, ok, busy;
  logic tx_start, wr_valid, wr_ack, wr_nack, rd_valid, rd_ready;
  logic [4:0] set_addr, set_rd_addr;
  logic [7:0] set_wdata, wr_data, rd_data, set_rd_data;
  eac_txn_t tx_req;
  int bad_count, samples_checked;

  // Short busy wait keeps erase and store runs brief
  eac_ctrl #(.BUSY_CYCLES(20)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .tx_start(tx_start), .tx_req(tx_req), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_ack(wr_ack), .wr_nack(wr_nack),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .set_we(set_we), .set_addr(set_addr), .set_wdata(set_wdata),
    .set_rd_addr(set_rd_addr), .set_rd_data(set_rd_data), .busy(busy));
  eac_host u_host (.sys_clk(sys_clk), .busy(busy), .wr_ack(wr_ack),
    .wr_nack(wr_nack), .rd_valid(rd_valid), .rd_data(rd_data),
    .tx_start(tx_start), .tx_req(tx_req), .wr_valid(wr_valid),
    .wr_data(wr_data), .rd_ready(rd_ready));

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr1(input logic [15:0] c, input logic [7:0] d);
    u_host.cmd(c, 1'b1);
    u_host.wb(d, ok);
  endtask : wr1

  task automatic rdn(input logic [15:0] c, input int n);
    u_host.cmd(c, 1'b0);
    u_host.rd(n);
  endtask : rdn

  // Busy bit masked: it may be caught high while the byte is fetched
  task automatic flags(input logic [7:0] e);
    rdn(16'hFE81, 1);
    chk("flags", e, u_host.q[0] & 8'hFE);
  endtask : flags

  task automatic setreg(input logic [4:0] a, input logic [7:0] d);
    set_we = 1'b1;
    set_addr = a;
    set_wdata = d;
    @(negedge sys_clk);
    set_we = 1'b0;
  endtask : setreg

  task automatic getreg(input logic [4:0] a, input logic [7:0] e);
    set_rd_addr = a;
    repeat (2) @(negedge sys_clk);
    chk("setting", e, set_rd_data);
  endtask : getreg

  task automatic t_powerup;
    flags(8'h20);
    rdn(16'h00D1, 1);
    chk("checksum", 8'h00, u_host.q[0]);
    getreg(5'h07, 8'hFF);
  endtask : t_powerup

  task automatic t_locked;
    wr1(16'h00D2, 8'h03);
    rdn(16'h00B0, 3);
    for (int i = 0; i < 3; i++) chk("hidden", 8'h00, u_host.q[i]);
    rdn(16'h00B6, 3);
    for (int i = 0; i < 3; i++) chk("open", 8'hFF, u_host.q[i]);
    wr1(16'h00B6, 8'h12);
    chk("locked write", 8'h00, {7'h00, ok});
    wr1(16'h00D4, 8'h06);
    chk("locked erase", 8'h00, {7'h00, ok});
    u_host.cmd(16'h0015, 1'b1);
    chk("locked store", 8'h00, {7'h00, busy});
  endtask : t_locked

  task automatic t_unlock;
    wr1(16'h00D5, 8'hFF);
    wr1(16'h00D5, 8'hFF);
    flags(8'h60);
  endtask : t_unlock

  // Offset 510 makes four bytes wrap inside the page
  task automatic t_wrap;
    u_host.cmd(16'h00D3, 1'b1);
    u_host.wb(8'hFE, ok);
    u_host.wb(8'h01, ok);
    u_host.cmd(16'h00B9, 1'b1);
    for (int i = 0; i < 4; i++) begin
      u_host.wb(8'hA0 + 8'(i), ok);
      chk("data ack", 8'h01, {7'h00, ok});
    end
    wr1(16'h00D2, 8'h04);
    rdn(16'h00B9, 4);
    for (int i = 0; i < 4; i++) chk("wrap", 8'hA0 + 8'(i), u_host.q[i]);
    rdn(16'h00B8, 4);
    for (int i = 0; i < 4; i++) chk("page", 8'hFF, u_host.q[i]);
    wr1(16'h00B0, 8'h55);
    chk("factory write", 8'h00, {7'h00, ok});
    wr1(16'h00B1, 8'h55);
    chk("user write", 8'h00, {7'h00, ok});
  endtask : t_wrap

  task automatic t_block;
    u_host.cmd(16'h00D3, 1'b1);
    u_host.wb(8'h00, ok);
    u_host.wb(8'h00, ok);
    u_host.cmd(16'h00B3, 1'b1);
    for (int i = 0; i < 257; i++) begin
      u_host.wb(8'(i), ok);
      chk("block ack", {7'h00, i < 256}, {7'h00, ok});
    end
    wr1(16'h00D2, 8'h00);
    u_host.slow = 1'b1;
    rdn(16'h00B3, 256);
    u_host.slow = 1'b0;
    chk("block size", 8'hFF, 8'(u_host.q.size() - 1));
    for (int i = 0; i < 256; i++) chk("block", 8'(i), u_host.q[i]);
  endtask : t_block

  task automatic t_erase;
    u_host.cmd(16'h00D4, 1'b1);
    u_host.wb(8'h03, ok);
    chk("erase ack", 8'h01, {7'h00, ok});
    u_host.wb(8'h04, ok);
    chk("busy nack", 8'h00, {7'h00, ok});
    wr1(16'h00D2, 8'h01);
    rdn(16'h00B3, 1);
    chk("erased", 8'hFF, u_host.q[0]);
    wr1(16'h00D4, 8'h01);
    chk("erase user", 8'h00, {7'h00, ok});
    wr1(16'h00D4, 8'h10);
    chk("erase range", 8'h00, {7'h00, ok});
  endtask : t_erase

  // 31 bytes of ones plus 0x0F give a sum of 0xFC
  task automatic t_store;
    setreg(5'h00, 8'h0F);
    u_host.cmd(16'h0015, 1'b1);
    chk("store busy", 8'h01, {7'h00, busy});
    rdn(16'h00D1, 1);
    chk("old sum", 8'h00, u_host.q[0]);
    setreg(5'h00, 8'h00);
    u_host.cmd(16'h0016, 1'b1);
    rdn(16'h00D1, 1);
    chk("new sum", 8'hFC, u_host.q[0]);
    getreg(5'h00, 8'h0F);
    flags(8'h40);
    u_host.cmd(16'h00D3, 1'b1);
    u_host.wb(8'h20, ok);
    u_host.wb(8'h00, ok);
    rdn(16'h00B1, 1);
    chk("stored sum", 8'hFC, u_host.q[0]);
    rdn(16'h00B0, 1);
    chk("factory kept", 8'hFF, u_host.q[0]);
  endtask : t_store

  task automatic t_password;
    wr1(16'h00D5, 8'hFF);
    wr1(16'h00D5, 8'h5A);
    wr1(16'h00D5, 8'h00);
    flags(8'h00);
    wr1(16'h00D5, 8'h5A);
    wr1(16'h00D5, 8'h5A);
    flags(8'h40);
    u_host.cmd(16'h0012, 1'b1);
    flags(8'h60);
    getreg(5'h00, 8'hFF);
    wr1(16'h00D5, 8'h00);
    wr1(16'h00D5, 8'hFF);
    wr1(16'h00D5, 8'hFF);
    flags(8'h60);
  endtask : t_password

  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    rst_n = 1'b0;
    set_we = 1'b0;
    set_addr = 5'h00;
    set_wdata = 8'h00;
    set_rd_addr = 5'h00;
    bad_count = 0;
    samples_checked = 0;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    t_powerup;
    t_locked;
    t_unlock;
    t_wrap;
    t_block;
    t_erase;
    t_store;
    t_password;
    final_report;
  end

  // Tests need about 2500 cycles; allow ten times that
  initial begin
    #200000;
    bad_count++;
    $display("watchdog expired");
    final_report;
  end
endmodule : eac_ctrl_tb
